//--- common/eps_pkg.sv
// Purpose: shared constants and types of the e-paper serial host port
// Assumes: host runs the serial clock idle low and changes data on its falling edge
// Notes:   link logic runs on the serial clock, user side on the system clock
//
// Overview of operation
// RULE_01 - traffic accepted only while chip select low
// RULE_02 - four-wire: select high data, low command
// RULE_03 - reset pin is active low
// RULE_04 - host sends nothing while busy pin low
// RULE_05 - busy low during waveform or sensor talk
// RULE_06 - strap low: four-wire, eight-bit transfers
// RULE_07 - strap high: three-wire, nine-bit transfers
// RULE_08 - mode set only by strap level
// RULE_09 - three-wire: select tied low, rising-edge sampling
// RULE_10 - writes and reads on the data line
// RULE_11 - four-wire writes sampled on rising clock
// RULE_12 - nine-bit: flag bit first, then MSB first
package eps_pkg;

  // bit counter width, wide enough for nine bits
  localparam int unsigned EPS_CNT_W = 4;

  // last bit index of a transfer in each mode
  localparam logic [3:0] EPS_LAST_4W = 4'h7;
  localparam logic [3:0] EPS_LAST_3W = 4'h8;

  // synchroniser depth for inputs from another domain
  localparam int unsigned EPS_SYNC_N = 3;

  // reset values
  localparam logic       EPS_BUSY_N_RST = 1'b0;
  localparam logic [7:0] EPS_BYTE_RST   = 8'h00;
  localparam logic [3:0] EPS_CNT_RST    = 4'h0;

  // interface mode picked by the strap
  typedef enum logic [1:0] {
    EPS_MODE_4W = 2'b01,
    EPS_MODE_3W = 2'b10
  } eps_mode_e;

  // one received unit: command/data flag and payload
  typedef struct packed {
    logic       is_data;
    logic [7:0] payload;
  } eps_rx_s;

  // mode from the synchronised strap level
  function automatic eps_mode_e eps_mode_of(input logic strap);
    eps_mode_of = strap ? EPS_MODE_3W : EPS_MODE_4W;
  endfunction

  // index of the last bit of a transfer for a mode
  function automatic logic [3:0] eps_last_bit(input eps_mode_e mode);
    eps_last_bit = (mode == EPS_MODE_3W) ? EPS_LAST_3W : EPS_LAST_4W;
  endfunction

endpackage

//--- hdl/eps_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d comes from another clock domain or a pin
// Notes:   q follows once the second and third stages agree
`timescale 1ns/1ps
module eps_sync
  import eps_pkg::*;
#(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, q_d;

  // filtered output takes a value only when stages two and three agree
  always_comb begin
    q_d = q_out;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        q_d[i] = s3_q[i];
      end
    end
  end

  // stage chain; s1 feeds only s2
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      q_out <= INIT;
    end else begin
      s1_q  <= d_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      q_out <= q_d;
    end
  end

endmodule

//--- hdl/eps_tgl_rx.sv
// Purpose: turns a toggle from another domain into a one-cycle pulse
// Assumes: source toggles at most once per several destination cycles
// Notes:   clr_in absorbs toggles without a pulse, used during soft reset
`timescale 1ns/1ps
module eps_tgl_rx
  import eps_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic clr_in,
  input  wire logic tgl_in,
  output logic      pulse_out
);

  logic tgl_s;
  logic last_q, last_d;
  logic pulse_d;

  eps_sync #(.W(1), .INIT(1'b0)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (tgl_in),
    .q_out  (tgl_s)
  );

  // edge of the filtered toggle, suppressed while cleared
  always_comb begin
    last_d  = tgl_s;
    pulse_d = (tgl_s != last_q) && !clr_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_q    <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      last_q    <= last_d;
      pulse_out <= pulse_d;
    end
  end

endmodule

//--- hdl/eps_host_port.sv
// Purpose: serial host port of an e-paper driver, four-wire or three-wire
// Assumes: serial clock idles low; host shifts MSB first, changes data on falling edge
// Notes:   received units are handed to the system clock domain by toggle;
//          a read byte is loaded from the user side and shifted out on demand
`timescale 1ns/1ps
module eps_host_port
  import eps_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic       SCL_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       DC_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_OUT,
  input  wire logic       RESET_N_IN,
  input  wire logic       INTERFACE_SELECT_STRAP_IN,
  input  wire logic       WAVEFORM_ACTIVE_IN,
  input  wire logic       TSENSOR_ACTIVE_IN,
  output logic            BUSY_N_OUT,
  output logic            NINE_BIT_MODE_OUT,
  output logic            RX_VALID_OUT,
  output logic [7:0]      RX_BYTE_OUT,
  output logic            RX_IS_DATA_OUT,
  input  wire logic       TX_LOAD_IN,
  input  wire logic [7:0] TX_BYTE_IN,
  output logic            TX_READY_OUT,
  output logic            TX_DONE_OUT
);

  // ------------------------------------------------------------------
  // link domain (serial clock)
  // ------------------------------------------------------------------

  // base reset: system reset or device reset pin, asynchronous assert
  logic link_rst_base;
  // frame reset: base reset or chip select released
  logic link_rst_frame;

  assign link_rst_base  = SYS_RST_IN | ~RESET_N_IN; // RULE_03
  assign link_rst_frame = link_rst_base | CS_N_IN;  // RULE_01

  // strap level from the system side, load toggle seen on the serial clock
  logic       strap_s;
  logic       tx_tgl_link_s;
  logic       tx_tgl_q, tx_tgl_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  eps_mode_e  link_mode;
  logic [3:0] link_last;
  logic       nine_bit;

  eps_sync #(.W(1), .INIT(1'b0)) u_link_sync (
    .clk_in (SCL_IN),
    .rst_in (link_rst_base),
    .d_in   (tx_tgl_q),
    .q_out  (tx_tgl_link_s)
  );

  // mode follows the strap level only; the serial clock stops between frames,
  // so the static strap is taken from its system-side synchroniser
  assign link_mode = eps_mode_of(strap_s);        // RULE_08
  assign link_last = eps_last_bit(link_mode);     // RULE_06 RULE_07
  assign nine_bit  = (link_mode == EPS_MODE_3W);

  // per-frame state, cleared whenever chip select is high
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic       flag_q, flag_d;
  logic       rd_slot_q, rd_slot_d;
  logic       done_rx, done_rd;
  logic       rd_pend;

  // persistent link state, survives chip select
  logic       rx_tgl_q, rx_tgl_d;
  eps_rx_s    rx_word_q, rx_word_d;
  logic       ack_tgl_q, ack_tgl_d;

  // a read is pending while the load toggle differs from our ack
  assign rd_pend = tx_tgl_link_s ^ ack_tgl_q;

  // bit counting and shifting on each rising serial clock edge
  always_comb begin
    cnt_d     = cnt_q + 4'h1;
    shift_d   = {shift_q[6:0], SDA_IN};          // RULE_11 RULE_09
    flag_d    = flag_q;
    rd_slot_d = rd_slot_q;
    done_rx   = 1'b0;
    done_rd   = 1'b0;
    if (nine_bit && (cnt_q == EPS_CNT_RST)) begin
      flag_d = SDA_IN;                           // RULE_12
      if (SDA_IN && rd_pend) begin
        rd_slot_d = 1'b1;                        // RULE_10
      end
    end
    if (cnt_q == link_last) begin
      cnt_d = EPS_CNT_RST;
      if (rd_slot_q) begin
        done_rd   = 1'b1;
        rd_slot_d = 1'b0;
      end else begin
        done_rx   = 1'b1;
        // four-wire read byte follows any byte while a read waits
        rd_slot_d = !nine_bit && rd_pend;        // RULE_10
      end
    end
  end

  always_ff @(posedge SCL_IN or posedge link_rst_frame) begin
    if (link_rst_frame) begin
      cnt_q     <= EPS_CNT_RST;
      shift_q   <= EPS_BYTE_RST;
      flag_q    <= 1'b0;
      rd_slot_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      shift_q   <= shift_d;
      flag_q    <= flag_d;
      rd_slot_q <= rd_slot_d;
    end
  end

  // hand-off of completed units and read acknowledge
  always_comb begin
    rx_tgl_d  = rx_tgl_q;
    rx_word_d = rx_word_q;
    ack_tgl_d = ack_tgl_q;
    if (done_rx) begin
      rx_tgl_d          = ~rx_tgl_q;
      rx_word_d.payload = shift_d;
      // flag bit in nine-bit mode, select pin in eight-bit mode
      rx_word_d.is_data = nine_bit ? flag_q : DC_IN; // RULE_02 RULE_12
    end
    if (done_rd) begin
      ack_tgl_d = ~ack_tgl_q;
    end
  end

  always_ff @(posedge SCL_IN or posedge link_rst_base) begin
    if (link_rst_base) begin
      rx_tgl_q  <= 1'b0;
      rx_word_q <= '0;
      ack_tgl_q <= 1'b0;
    end else begin
      rx_tgl_q  <= rx_tgl_d;
      rx_word_q <= rx_word_d;
      ack_tgl_q <= ack_tgl_d;
    end
  end

  // read data launched on falling edges so the host samples on rising edges
  logic [3:0] pay_pos;
  logic [2:0] pay_idx;
  logic       sda_out_d, sda_oe_d;

  always_comb begin
    pay_pos   = nine_bit ? (cnt_q - 4'h1) : cnt_q;
    pay_idx   = 3'(4'h7 - pay_pos);
    sda_oe_d  = rd_slot_q;                       // RULE_10
    sda_out_d = rd_slot_q ? tx_byte_q[pay_idx] : 1'b0;
  end

  // drive released as soon as chip select rises
  always_ff @(negedge SCL_IN or posedge link_rst_frame) begin
    if (link_rst_frame) begin
      SDA_OUT    <= 1'b0;
      SDA_OE_OUT <= 1'b0;                        // RULE_01
    end else begin
      SDA_OUT    <= sda_out_d;
      SDA_OE_OUT <= sda_oe_d;
    end
  end

  // ------------------------------------------------------------------
  // system clock domain
  // ------------------------------------------------------------------

  logic rst_n_s;
  logic soft_rst;

  eps_sync #(.W(2), .INIT(2'b00)) u_sys_sync (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .d_in   ({RESET_N_IN, INTERFACE_SELECT_STRAP_IN}),
    .q_out  ({rst_n_s, strap_s})
  );

  // device logic held while the reset pin is low
  assign soft_rst = !rst_n_s;                    // RULE_03

  logic rx_pulse;
  logic ack_pulse;

  eps_tgl_rx u_rx_evt (
    .clk_in    (CLK_IN),
    .rst_in    (SYS_RST_IN),
    .clr_in    (soft_rst),
    .tgl_in    (rx_tgl_q),
    .pulse_out (rx_pulse)
  );

  eps_tgl_rx u_ack_evt (
    .clk_in    (CLK_IN),
    .rst_in    (SYS_RST_IN),
    .clr_in    (soft_rst),
    .tgl_in    (ack_tgl_q),
    .pulse_out (ack_pulse)
  );

  // user-side state
  logic       rx_valid_d;
  logic [7:0] rx_byte_d;
  logic       rx_is_data_d;
  logic       armed_q, armed_d;
  logic       tx_ready_d, tx_done_d;
  logic       busy_n_d;
  logic       nine_d;

  // capture received units, manage the read byte, drive busy
  always_comb begin
    rx_valid_d   = 1'b0;
    rx_byte_d    = RX_BYTE_OUT;
    rx_is_data_d = RX_IS_DATA_OUT;
    tx_tgl_d     = tx_tgl_q;
    tx_byte_d    = tx_byte_q;
    armed_d      = armed_q;
    tx_done_d    = 1'b0;
    nine_d       = (eps_mode_of(strap_s) == EPS_MODE_3W); // RULE_08
    // busy low while the panel is driven or the sensor is addressed
    busy_n_d     = !(WAVEFORM_ACTIVE_IN || TSENSOR_ACTIVE_IN); // RULE_05 RULE_04
    if (rx_pulse) begin
      // word is stable for a whole transfer after its toggle
      rx_valid_d   = 1'b1;
      rx_byte_d    = rx_word_q.payload;
      rx_is_data_d = rx_word_q.is_data;
    end
    if (ack_pulse) begin
      armed_d   = 1'b0;
      tx_done_d = 1'b1;
    end
    // byte held constant while armed, so the link may read it any time
    if (TX_LOAD_IN && !armed_q) begin
      tx_byte_d = TX_BYTE_IN;
      tx_tgl_d  = ~tx_tgl_q;
      armed_d   = 1'b1;
    end
    tx_ready_d = !armed_d;
    if (soft_rst) begin
      rx_valid_d   = 1'b0;
      rx_byte_d    = EPS_BYTE_RST;
      rx_is_data_d = 1'b0;
      tx_tgl_d     = 1'b0;
      tx_byte_d    = EPS_BYTE_RST;
      armed_d      = 1'b0;
      tx_ready_d   = 1'b0;
      tx_done_d    = 1'b0;
      busy_n_d     = EPS_BUSY_N_RST;             // RULE_03
      nine_d       = 1'b0;                       // RULE_03
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RX_VALID_OUT      <= 1'b0;
      RX_BYTE_OUT       <= EPS_BYTE_RST;
      RX_IS_DATA_OUT    <= 1'b0;
      tx_tgl_q          <= 1'b0;
      tx_byte_q         <= EPS_BYTE_RST;
      armed_q           <= 1'b0;
      TX_READY_OUT      <= 1'b0;
      TX_DONE_OUT       <= 1'b0;
      BUSY_N_OUT        <= EPS_BUSY_N_RST;
      NINE_BIT_MODE_OUT <= 1'b0;
    end else begin
      RX_VALID_OUT      <= rx_valid_d;
      RX_BYTE_OUT       <= rx_byte_d;
      RX_IS_DATA_OUT    <= rx_is_data_d;
      tx_tgl_q          <= tx_tgl_d;
      tx_byte_q         <= tx_byte_d;
      armed_q           <= armed_d;
      TX_READY_OUT      <= tx_ready_d;
      TX_DONE_OUT       <= tx_done_d;
      BUSY_N_OUT        <= busy_n_d;
      NINE_BIT_MODE_OUT <= nine_d;
    end
  end

endmodule

//--- tb/eps_host_port_assertions.sv
// Purpose: port checker for the serial host port
// Assumes: one system clock domain, async active-high reset
// Notes:   bound to every instance of the port
`timescale 1ns/1ps
module eps_host_port_assertions (
  input wire logic       CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       SCL_IN,
  input wire logic       CS_N_IN,
  input wire logic       RESET_N_IN,
  input wire logic       INTERFACE_SELECT_STRAP_IN,
  input wire logic       WAVEFORM_ACTIVE_IN,
  input wire logic       TSENSOR_ACTIVE_IN,
  input wire logic       BUSY_N_OUT,
  input wire logic       NINE_BIT_MODE_OUT,
  input wire logic       RX_VALID_OUT,
  input wire logic [7:0] RX_BYTE_OUT,
  input wire logic       RX_IS_DATA_OUT,
  input wire logic       SDA_OE_OUT,
  input wire logic       TX_LOAD_IN,
  input wire logic       TX_READY_OUT,
  input wire logic       TX_DONE_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // strap held steady out of reset
  sequence s_hi;
    (INTERFACE_SELECT_STRAP_IN && RESET_N_IN)[*6];
  endsequence
  sequence s_lo;
    (!INTERFACE_SELECT_STRAP_IN && RESET_N_IN)[*6];
  endsequence
  // busy, reset and mode
  a_busy_on: assert property ((WAVEFORM_ACTIVE_IN || TSENSOR_ACTIVE_IN) |=> !BUSY_N_OUT)
    else $error("busy not shown while active");
  a_busy_off: assert property ((!WAVEFORM_ACTIVE_IN && !TSENSOR_ACTIVE_IN && RESET_N_IN)[*8] |-> BUSY_N_OUT)
    else $error("busy held while idle");
  a_reset_pin: assert property ((!RESET_N_IN)[*6] |-> !BUSY_N_OUT && !TX_READY_OUT && !NINE_BIT_MODE_OUT)
    else $error("outputs active under reset pin");
  a_mode_three: assert property (s_hi ##1 s_hi |-> NINE_BIT_MODE_OUT)
    else $error("nine-bit mode not set");
  a_mode_four: assert property (s_lo ##1 s_lo |-> !NINE_BIT_MODE_OUT)
    else $error("eight-bit mode not set");
  // receive path
  a_rx_needs_cs: assert property (CS_N_IN[*8] |-> !RX_VALID_OUT)
    else $error("unit received while deselected");
  a_rx_holds: assert property (RX_VALID_OUT |=> !RX_VALID_OUT && $stable(RX_BYTE_OUT) && $stable(RX_IS_DATA_OUT))
    else $error("received unit not held");
  // read path
  a_oe_needs_cs: assert property (SDA_OE_OUT |-> !CS_N_IN)
    else $error("data line driven while deselected");
  a_oe_on_fall: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN)
    else $error("data line taken on rising clock");
  a_tx_load_taken: assert property (TX_READY_OUT && TX_LOAD_IN |=> !TX_READY_OUT)
    else $error("read byte load not taken");
  a_done_ready: assert property (TX_DONE_OUT |-> TX_READY_OUT)
    else $error("ready missing at read end");
  c_data_unit: cover property (RX_VALID_OUT && RX_IS_DATA_OUT);
  c_read_nine: cover property (TX_DONE_OUT && NINE_BIT_MODE_OUT);
  c_busy: cover property (!BUSY_N_OUT && WAVEFORM_ACTIVE_IN);
endmodule
bind eps_host_port eps_host_port_assertions chk_u (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SCL_IN(SCL_IN), .CS_N_IN(CS_N_IN), .RESET_N_IN(RESET_N_IN),
  .INTERFACE_SELECT_STRAP_IN(INTERFACE_SELECT_STRAP_IN), .WAVEFORM_ACTIVE_IN(WAVEFORM_ACTIVE_IN),
  .TSENSOR_ACTIVE_IN(TSENSOR_ACTIVE_IN), .BUSY_N_OUT(BUSY_N_OUT), .NINE_BIT_MODE_OUT(NINE_BIT_MODE_OUT),
  .RX_VALID_OUT(RX_VALID_OUT), .RX_BYTE_OUT(RX_BYTE_OUT), .RX_IS_DATA_OUT(RX_IS_DATA_OUT),
  .SDA_OE_OUT(SDA_OE_OUT), .TX_LOAD_IN(TX_LOAD_IN), .TX_READY_OUT(TX_READY_OUT), .TX_DONE_OUT(TX_DONE_OUT));

//--- tb/eps_host_model.sv
// Purpose: host model driving the serial link
// Assumes: clock idles low, data changes after the falling edge
// Notes:   clock runs only inside unit calls
`timescale 1ns/1ps
module eps_host_model (
  output logic      scl_out,
  output logic      cs_n_out,
  output logic      dc_out,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'h0;
    cs_n_out = 1'h1;
    dc_out = 1'h0;
    sda_out = 1'h0;
    sda_oe_out = 1'h1;
  end
  // frame open, offset from the system clock phase
  task automatic start();
    #3 cs_n_out = 1'h0;
    #100;
  endtask
  task automatic stop();
    #100 cs_n_out = 1'h1;
    #200;
  endtask
  // one unit: flag bit in nine-bit mode, then payload msb first
  task automatic unit(input logic nb, input logic dcv, input logic [7:0] b, input logic rd, output logic [7:0] got);
    logic [8:0] w;
    w = {dcv, b};
    got = 8'h00;
    dc_out = nb ? 1'h0 : dcv;
    for (int i = (nb ? 8 : 7); i >= 0; i--) begin
      sda_oe_out = !(rd && i < 8);
      sda_out = w[i];
      #80 scl_out = 1'h1;
      got = {got[6:0], sda_in};
      #80 scl_out = 1'h0;
    end
    sda_oe_out = 1'h1;
  endtask
endmodule

//--- tb/test_epaper_serial_host_port.sv
// Purpose: self-checking bench for the serial host port
// Assumes: host model drives the link, bench drives the user side
// Notes:   fixed seed, corner units first in each write frame
`timescale 1ns/1ps
module test_epaper_serial_host_port;
  import eps_pkg::*;
  logic       clk, rst, reset_n, strap, wav, tsen, tx_load;
  logic [7:0] tx_byte, g;
  wire        scl, cs_n, dc, sda_h, sda_h_oe, sda_o, sda_oe, sda_w;
  wire        busy_n, nine, rx_v, rx_is, tx_rdy, tx_done;
  wire  [7:0] rx_b;
  int         failures, tests_run, seed, dones;
  logic [8:0] rxq[$], expq[$];
  // released line shows the inverse of the last host bit
  assign sda_w = sda_oe ? sda_o : (sda_h_oe ? sda_h : ~sda_h);
  eps_host_port dut_u (
    .CLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .CS_N_IN(cs_n), .DC_IN(dc), .SDA_IN(sda_w),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .RESET_N_IN(reset_n), .INTERFACE_SELECT_STRAP_IN(strap),
    .WAVEFORM_ACTIVE_IN(wav), .TSENSOR_ACTIVE_IN(tsen), .BUSY_N_OUT(busy_n), .NINE_BIT_MODE_OUT(nine),
    .RX_VALID_OUT(rx_v), .RX_BYTE_OUT(rx_b), .RX_IS_DATA_OUT(rx_is), .TX_LOAD_IN(tx_load),
    .TX_BYTE_IN(tx_byte), .TX_READY_OUT(tx_rdy), .TX_DONE_OUT(tx_done));
  eps_host_model hm_u (.scl_out(scl), .cs_n_out(cs_n), .dc_out(dc), .sda_out(sda_h), .sda_oe_out(sda_h_oe),
    .sda_in(sda_w));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // collect received units and finished reads, away from the launching edge
  always @(negedge clk) begin
    if (rx_v === 1'h1) rxq.push_back({rx_is, rx_b});
    if (tx_done === 1'h1) dones++;
  end
  function automatic logic exp_busy_n(input logic w, input logic t);
    return !(w || t);
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // compare collected units with the expected list
  task automatic drain();
    repeat (10) @(negedge clk);
    check(9'(rxq.size()), 9'(expq.size()));
    foreach (expq[k]) if (k < rxq.size()) check(rxq[k], expq[k]);
    rxq.delete();
    expq.delete();
  endtask
  task automatic wait_idle();
    for (int w = 0; w < 50 && busy_n !== 1'h1; w++) @(negedge clk);
  endtask
  task automatic run_writes(input logic nb, input int n);
    logic [8:0] u;
    wait_idle();
    hm_u.start();
    for (int k = 0; k < n; k++) begin
      u = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : 9'($random(seed));
      hm_u.unit(nb, u[8], u[7:0], 1'h0, g);
      expq.push_back(u);
    end
    hm_u.stop();
    drain();
  endtask
  task automatic do_read(input logic nb);
    logic [7:0] b, c;
    int d0;
    b = 8'($random(seed));
    c = 8'($random(seed));
    for (int w = 0; w < 50 && tx_rdy !== 1'h1; w++) @(negedge clk);
    tx_load = 1'h1;
    tx_byte = b;
    @(negedge clk);
    tx_load = 1'h0;
    repeat (10) @(negedge clk);
    d0 = dones;
    wait_idle();
    hm_u.start();
    // leading command unit gives the link edges to see the pending read
    hm_u.unit(nb, 1'h0, c, 1'h0, g);
    expq.push_back({1'h0, c});
    hm_u.unit(nb, 1'h1, 8'h00, 1'h1, g);
    hm_u.stop();
    check(9'(g), 9'(b));
    check(9'(dones - d0), 9'h001);
    drain();
  endtask
  initial begin
    seed = 55136;
    rst = 1'h1;
    reset_n = 1'h1;
    strap = 1'h0;
    {wav, tsen} = 2'h0;
    tx_load = 1'h0;
    tx_byte = 8'h00;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    repeat (12) @(negedge clk);
    check(9'(nine), 9'h000);
    for (int i = 0; i < 8; i++) begin
      {wav, tsen} = (i < 4) ? 2'(i) : 2'($random(seed));
      repeat (2) @(negedge clk);
      check(9'(busy_n), 9'(exp_busy_n(wav, tsen)));
    end
    {wav, tsen} = 2'h0;
    $display("test busy done");
    run_writes(1'h0, 6);
    hm_u.unit(1'h0, 1'h1, 8'ha5, 1'h0, g);
    drain();
    $display("test four-wire writes done");
    do_read(1'h0);
    $display("test four-wire read done");
    reset_n = 1'h0;
    strap = 1'h1;
    repeat (8) @(negedge clk);
    check(9'({busy_n, tx_rdy, nine}), 9'h000);
    reset_n = 1'h1;
    repeat (12) @(negedge clk);
    check(9'(nine), 9'h001);
    run_writes(1'h1, 6);
    do_read(1'h1);
    $display("test three-wire done");
    report_and_stop();
  end
  initial begin
    #500000;
    failures++;
    report_and_stop();
  end
endmodule
